// ==== include/sad_pkg.sv ====
package sad_pkg;
  // organisation selector
  typedef enum logic [1:0] {
    SAD_ORG_X4,
    SAD_ORG_X8,
    SAD_ORG_X16
  } sad_org_e;

  // decoded command
  typedef enum logic [2:0] {
    SAD_CMD_NOP,
    SAD_CMD_ACTIVE,
    SAD_CMD_READ,
    SAD_CMD_WRITE,
    SAD_CMD_PRECHARGE,
    SAD_CMD_LOAD_MODE,
    SAD_CMD_OTHER
  } sad_cmd_e;

  localparam int SAD_BANKS        = 4;
  localparam int SAD_BANK_W       = 2;
  localparam int SAD_ADDR_W       = 12;
  localparam int SAD_COL_W        = 11;
  localparam int SAD_DQ_MAX_W     = 16;
  localparam int SAD_DQ_X4_W      = 4;
  localparam int SAD_DQ_X8_W      = 8;
  localparam int SAD_SCOPE_BIT    = 10;
  localparam int SAD_COL_HI_BIT   = 11;
  localparam int SAD_COL_WIDE_MSB   = 9;
  localparam int SAD_COL_NARROW_MSB = 8;
  localparam int SAD_FIFO_DEPTH   = 8;
  localparam logic [11:0] SAD_ADDR_RST = 12'h000;
  localparam logic [3:0]  SAD_BANK_RST = 4'h0;
endpackage : sad_pkg

// ==== design/sad_fifo.sv ====
`timescale 1ns/10ps
module sad_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("sad_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0]      wr_reg;
  logic [PW:0]      rd_reg;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full      = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
  assign empty     = (wr_reg == rd_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_reg[rd_reg[PW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg[PW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
    full && !pop |=> full)
    else $error("fifo lost fullness without a pop");
endmodule : sad_fifo

// ==== design/sad_decode.sv ====
`timescale 1ns/10ps
module sad_decode
  import sad_pkg::*;
#(
  parameter sad_pkg::sad_org_e ORG = sad_pkg::SAD_ORG_X16
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset_n,
  input  wire logic                              cs_n,
  input  wire logic                              ras_n,
  input  wire logic                              cas_n,
  input  wire logic                              we_n,
  input  wire logic [sad_pkg::SAD_BANK_W-1:0]    bank_sel,
  input  wire logic [sad_pkg::SAD_ADDR_W-1:0]    addr,
  input  wire logic [sad_pkg::SAD_DQ_MAX_W-1:0]  dq_in,
  output logic      [sad_pkg::SAD_DQ_MAX_W-1:0]  dq_out,
  output logic      [sad_pkg::SAD_DQ_MAX_W-1:0]  dq_oe,
  output logic      [sad_pkg::SAD_BANKS-1:0]     bank_open,
  output logic      [sad_pkg::SAD_ADDR_W-1:0]    row_addr,
  output logic      [sad_pkg::SAD_COL_W-1:0]     col_addr,
  output logic      [sad_pkg::SAD_BANK_W-1:0]    acc_bank,
  output logic                                   acc_valid,
  output logic                                   acc_write,
  output logic                                   auto_precharge,
  output logic      [sad_pkg::SAD_ADDR_W-1:0]    mode_opcode,
  output logic                                   mode_load,
  output logic                                   wr_valid,
  output logic      [sad_pkg::SAD_DQ_MAX_W-1:0]  wr_data,
  input  wire logic                              wr_ready,
  input  wire logic                              rd_valid,
  input  wire logic [sad_pkg::SAD_DQ_MAX_W-1:0]  rd_data,
  output logic                                   rd_ready
);
  import sad_pkg::*;

  localparam int DQ_W = (ORG == SAD_ORG_X4) ? SAD_DQ_X4_W :
                        (ORG == SAD_ORG_X8) ? SAD_DQ_X8_W : SAD_DQ_MAX_W;
  localparam int FW = SAD_DQ_MAX_W;

  initial
  begin
    if (ORG != SAD_ORG_X4 && ORG != SAD_ORG_X8 && ORG != SAD_ORG_X16)
      $error("sad_decode: unsupported organisation");
  end

  // command decode from the four strobes
  function automatic sad_cmd_e decode_cmd(input logic cs, input logic ras,
                                          input logic cas, input logic we);
    if (cs)
      decode_cmd = SAD_CMD_NOP;
    else if (!ras && cas && we)
      decode_cmd = SAD_CMD_ACTIVE;
    else if (ras && !cas && we)
      decode_cmd = SAD_CMD_READ;
    else if (ras && !cas && !we)
      decode_cmd = SAD_CMD_WRITE;
    else if (!ras && cas && !we)
      decode_cmd = SAD_CMD_PRECHARGE;
    else if (!ras && !cas && !we)
      decode_cmd = SAD_CMD_LOAD_MODE;
    else if (ras && cas && we)
      decode_cmd = SAD_CMD_NOP;
    else
      decode_cmd = SAD_CMD_OTHER;
  endfunction : decode_cmd

  // column select per organisation
  function automatic logic [SAD_COL_W-1:0] pick_col(input logic [SAD_ADDR_W-1:0] a);
    if (ORG == SAD_ORG_X4)
      pick_col = {a[SAD_COL_HI_BIT], a[SAD_COL_WIDE_MSB:0]};
    else if (ORG == SAD_ORG_X8)
      pick_col = {1'b0, a[SAD_COL_WIDE_MSB:0]};
    else
      pick_col = {2'b00, a[SAD_COL_NARROW_MSB:0]};
  endfunction : pick_col

  function automatic logic [FW-1:0] lane_mask(input logic [FW-1:0] d);
    lane_mask = d & FW'((1 << DQ_W) - 1);
  endfunction : lane_mask

  logic       rst_s1_reg;
  logic       rst_n_reg;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  sad_cmd_e                cmd;
  logic                    precharge_scope_bit;
  assign cmd                 = decode_cmd(cs_n, ras_n, cas_n, we_n);
  assign precharge_scope_bit = addr[SAD_SCOPE_BIT];

  // per-bank row store
  logic [SAD_ADDR_W-1:0] row_reg [SAD_BANKS];
  always_ff @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      for (int i = 0; i < SAD_BANKS; i++)
        row_reg[i] <= SAD_ADDR_RST;
      bank_open <= SAD_BANK_RST;
    end
    else if (cmd == SAD_CMD_ACTIVE)
    begin
      row_reg[bank_sel]   <= addr;
      bank_open[bank_sel] <= 1'b1;
    end
    else if (cmd == SAD_CMD_PRECHARGE)
    begin
      if (precharge_scope_bit)
        bank_open <= '0;
      else
        bank_open[bank_sel] <= 1'b0;
    end
    else if ((cmd == SAD_CMD_READ || cmd == SAD_CMD_WRITE) && precharge_scope_bit)
      bank_open[bank_sel] <= 1'b0;
  end

  // access strobe, column and auto-precharge flag
  always_ff @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      acc_valid      <= 1'b0;
      acc_write      <= 1'b0;
      acc_bank       <= '0;
      col_addr       <= '0;
      row_addr       <= SAD_ADDR_RST;
      auto_precharge <= 1'b0;
    end
    else
    begin
      acc_valid <= (cmd == SAD_CMD_READ || cmd == SAD_CMD_WRITE);
      if (cmd == SAD_CMD_READ || cmd == SAD_CMD_WRITE)
      begin
        acc_write      <= (cmd == SAD_CMD_WRITE);
        acc_bank       <= bank_sel;
        col_addr       <= pick_col(addr);
        row_addr       <= row_reg[bank_sel];
        auto_precharge <= precharge_scope_bit;
      end
    end
  end

  // mode register load
  always_ff @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      mode_opcode <= SAD_ADDR_RST;
      mode_load   <= 1'b0;
    end
    else
    begin
      mode_load <= (cmd == SAD_CMD_LOAD_MODE);
      if (cmd == SAD_CMD_LOAD_MODE)
        mode_opcode <= addr;
    end
  end

  // write data path through the fifo
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic          fifo_pop;
  logic          wr_push;
  assign wr_push  = (cmd == SAD_CMD_WRITE);
  assign fifo_pop = fifo_out_valid && (!wr_valid || wr_ready);

  sad_fifo #(
    .WIDTH (FW),
    .DEPTH (SAD_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n_reg),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   (lane_mask(dq_in)),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  logic wr_drop_reg;
  always_ff @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wr_valid    <= 1'b0;
      wr_data     <= '0;
      wr_drop_reg <= 1'b0;
    end
    else
    begin
      if (fifo_pop)
      begin
        wr_valid <= 1'b1;
        wr_data  <= fifo_out_data;
      end
      else if (wr_ready)
        wr_valid <= 1'b0;
      wr_drop_reg <= wr_push && !fifo_in_ready;
    end
  end

  // read data drive, only the organisation's lanes are enabled
  always_ff @(posedge core_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      dq_out   <= '0;
      dq_oe    <= '0;
      rd_ready <= 1'b0;
    end
    else
    begin
      rd_ready <= 1'b1;
      if (rd_valid && rd_ready)
      begin
        dq_out <= lane_mask(rd_data);
        dq_oe  <= lane_mask('1);
      end
      else
        dq_oe <= '0;
    end
  end

  AST_ROW_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_ACTIVE |=> row_reg[$past(bank_sel)] == $past(addr))
    else $error("row not latched on activate");
  AST_BANK_OPEN: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_ACTIVE |=> bank_open[$past(bank_sel)])
    else $error("activated bank not open");
  AST_COL_PICK: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (cmd == SAD_CMD_READ || cmd == SAD_CMD_WRITE)
    |=> acc_valid && (ORG == SAD_ORG_X4 ? col_addr == {$past(addr[SAD_COL_HI_BIT]),
                                          $past(addr[SAD_COL_WIDE_MSB:0])} :
                      ORG == SAD_ORG_X8 ? col_addr == {1'b0, $past(addr[SAD_COL_WIDE_MSB:0])} :
                      col_addr == {2'b00, $past(addr[SAD_COL_NARROW_MSB:0])}))
    else $error("wrong column");
  AST_AUTO_PRE: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (cmd == SAD_CMD_READ || cmd == SAD_CMD_WRITE) && precharge_scope_bit
    |=> auto_precharge && !bank_open[acc_bank])
    else $error("auto precharge missed");
  AST_PRE_ALL: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_PRECHARGE && precharge_scope_bit |=> bank_open == '0)
    else $error("precharge all left a bank open");
  AST_PRE_ONE: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_PRECHARGE && !precharge_scope_bit
    |=> !bank_open[$past(bank_sel)] && ((bank_open | (4'h1 << $past(bank_sel)))
        == ($past(bank_open) | (4'h1 << $past(bank_sel)))))
    else $error("single precharge touched other banks");
  AST_MODE_OP: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_LOAD_MODE |=> mode_load && mode_opcode == $past(addr))
    else $error("mode opcode not taken");
  AST_DQ_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (dq_oe & ~lane_mask('1)) == '0 && (wr_data & ~lane_mask('1)) == '0)
    else $error("unused data lane active");
  AST_DESELECT: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cs_n |=> !acc_valid && !mode_load)
    else $error("command acted while deselected");
  AST_NO_ACCESS: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    !(cmd == SAD_CMD_READ || cmd == SAD_CMD_WRITE) |=> !acc_valid)
    else $error("access strobe without read or write");
  AST_ACT_OTHERS: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_ACTIVE
    |=> (bank_open | (4'h1 << $past(bank_sel)))
        == ($past(bank_open) | (4'h1 << $past(bank_sel))))
    else $error("activate touched another bank");
  AST_MODE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd != SAD_CMD_LOAD_MODE |=> !mode_load && $stable(mode_opcode))
    else $error("mode opcode changed without a load");
  AST_WR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write word changed before acceptance");
  AST_OE_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    !(rd_valid && rd_ready) |=> dq_oe == '0)
    else $error("data lanes driven without read data");

  COV_ACTIVE_READ: cover property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_ACTIVE ##[1:4] cmd == SAD_CMD_READ);
  COV_WRITE_AP: cover property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_WRITE && precharge_scope_bit);
  COV_PRE_ALL: cover property (@(posedge core_clk) disable iff (!rst_n_reg)
    cmd == SAD_CMD_PRECHARGE && precharge_scope_bit && bank_open != '0);
  COV_WR_DROP: cover property (@(posedge core_clk) disable iff (!rst_n_reg) wr_drop_reg);
  COV_READ_DRIVE: cover property (@(posedge core_clk) disable iff (!rst_n_reg)
    rd_valid && rd_ready);
endmodule : sad_decode

// ==== verif/sad_ctrl_model.sv ====
`timescale 1ns/10ps
module sad_ctrl_model
(
  input  wire logic                        core_clk,
  output logic                             cs_n,
  output logic                             ras_n,
  output logic                             cas_n,
  output logic                             we_n,
  output logic [sad_pkg::SAD_BANK_W-1:0]   bank_sel,
  output logic [sad_pkg::SAD_ADDR_W-1:0]   addr,
  output logic [sad_pkg::SAD_DQ_MAX_W-1:0] dq_in
);
  import sad_pkg::*;

  initial
  begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_sel = 2'h0;
    addr = 12'h000;
    dq_in = 16'h0000;
  end

  // row, column and write strobe levels of each command
  function automatic logic [2:0] strobe_code(input sad_cmd_e cmd);
    case (cmd)
      SAD_CMD_ACTIVE:    strobe_code = 3'h3;
      SAD_CMD_READ:      strobe_code = 3'h5;
      SAD_CMD_WRITE:     strobe_code = 3'h4;
      SAD_CMD_PRECHARGE: strobe_code = 3'h2;
      SAD_CMD_LOAD_MODE: strobe_code = 3'h0;
      SAD_CMD_OTHER:     strobe_code = 3'h1;
      default:           strobe_code = 3'h7;
    endcase
  endfunction : strobe_code

  // one command, launched just after an edge and held until the next edge
  task automatic issue(input sad_cmd_e cmd, input logic [1:0] bank,
                       input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = strobe_code(cmd);
    bank_sel = bank;
    addr = a;
    dq_in = d;
  endtask : issue

  // command strobes with chip-select high, which the decoder must ignore
  task automatic issue_masked(input sad_cmd_e cmd, input logic [1:0] bank,
                              input logic [11:0] a);
    @(posedge core_clk);
    #1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = strobe_code(cmd);
    bank_sel = bank;
    addr = a;
  endtask : issue_masked

  // deselected: lines no longer carry the last value
  task automatic idle();
    @(posedge core_clk);
    #1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_sel = ~bank_sel;
    addr = ~addr;
    dq_in = ~dq_in;
  endtask : idle
endmodule : sad_ctrl_model

// ==== verif/sad_decode_tb.sv ====
`timescale 1ns/10ps
module sad_decode_tb;
  import sad_pkg::*;
  logic        core_clk, reset_n, cs_n, ras_n, cas_n, we_n;
  logic        acc_valid, acc_write, auto_precharge, mode_load;
  logic        wr_valid, wr_ready, rd_valid, rd_ready;
  logic [1:0]  bank_sel, acc_bank;
  logic [3:0]  bank_open;
  logic [10:0] col_addr;
  logic [11:0] addr, row_addr, mode_opcode;
  logic [15:0] dq_in, dq_out, dq_oe, wr_data, rd_data;
  logic [10:0] col_x4, col_x8;
  logic [15:0] oe_x4, oe_x8;
  int          errors;
  int          samples_checked;

  sad_decode #(.ORG(SAD_ORG_X16)) u_sad_decode (
    .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_sel(bank_sel), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .bank_open(bank_open), .row_addr(row_addr), .col_addr(col_addr),
    .acc_bank(acc_bank), .acc_valid(acc_valid), .acc_write(acc_write),
    .auto_precharge(auto_precharge), .mode_opcode(mode_opcode), .mode_load(mode_load),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready));

  // narrower organisations share the command bus; column and lane enables are watched
  sad_decode #(.ORG(SAD_ORG_X4)) u_sad_decode_x4 (
    .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_sel(bank_sel), .addr(addr), .dq_in(dq_in), .dq_out(),
    .dq_oe(oe_x4), .bank_open(), .row_addr(), .col_addr(col_x4), .acc_bank(),
    .acc_valid(), .acc_write(), .auto_precharge(), .mode_opcode(), .mode_load(),
    .wr_valid(), .wr_data(), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready());

  sad_decode #(.ORG(SAD_ORG_X8)) u_sad_decode_x8 (
    .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_sel(bank_sel), .addr(addr), .dq_in(dq_in), .dq_out(),
    .dq_oe(oe_x8), .bank_open(), .row_addr(), .col_addr(col_x8), .acc_bank(),
    .acc_valid(), .acc_write(), .auto_precharge(), .mode_opcode(), .mode_load(),
    .wr_valid(), .wr_data(), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready());

  sad_ctrl_model u_sad_ctrl_model (
    .core_clk(core_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_sel(bank_sel), .addr(addr), .dq_in(dq_in));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic test_open_read();
    u_sad_ctrl_model.issue(SAD_CMD_ACTIVE, 2'h1, 12'h123, 16'h0000);
    u_sad_ctrl_model.idle();
    check("bank_open", 16'(bank_open), 16'h0002);
    u_sad_ctrl_model.issue(SAD_CMD_READ, 2'h1, 12'hF05, 16'h0000);
    u_sad_ctrl_model.idle();
    check("acc_valid", 16'(acc_valid), 16'h0001);
    check("acc_write", 16'(acc_write), 16'h0000);
    check("col_addr", 16'(col_addr), 16'h0105);
    check("col_addr_x4", 16'(col_x4), 16'h0705);
    check("col_addr_x8", 16'(col_x8), 16'h0305);
    check("auto_precharge", 16'(auto_precharge), 16'h0001);
    check("acc_bank", 16'(acc_bank), 16'h0001);
    check("row_addr", 16'(row_addr), 16'h0123);
    check("bank_open", 16'(bank_open), 16'h0000);
    $display("test_open_read done");
  endtask : test_open_read

  task automatic test_precharge();
    u_sad_ctrl_model.issue(SAD_CMD_ACTIVE, 2'h0, 12'hFFF, 16'h0000);
    u_sad_ctrl_model.issue(SAD_CMD_ACTIVE, 2'h2, 12'h000, 16'h0000);
    u_sad_ctrl_model.issue(SAD_CMD_ACTIVE, 2'h3, 12'h800, 16'h0000);
    u_sad_ctrl_model.issue(SAD_CMD_PRECHARGE, 2'h2, 12'hBFF, 16'h0000);
    u_sad_ctrl_model.idle();
    check("bank_open", 16'(bank_open), 16'h0009);
    u_sad_ctrl_model.issue(SAD_CMD_PRECHARGE, 2'h1, 12'h400, 16'h0000);
    u_sad_ctrl_model.idle();
    check("bank_open", 16'(bank_open), 16'h0000);
    $display("test_precharge done");
  endtask : test_precharge

  task automatic test_mode();
    u_sad_ctrl_model.issue(SAD_CMD_LOAD_MODE, 2'h3, 12'h0A5, 16'h0000);
    u_sad_ctrl_model.idle();
    check("mode_load", 16'(mode_load), 16'h0001);
    check("mode_opcode", 16'(mode_opcode), 16'h00A5);
    u_sad_ctrl_model.idle();
    check("mode_load", 16'(mode_load), 16'h0000);
    $display("test_mode done");
  endtask : test_mode

  task automatic test_write_fifo();
    int n;
    n = 0;
    u_sad_ctrl_model.issue(SAD_CMD_ACTIVE, 2'h0, 12'h0F0, 16'h0000);
    for (int i = 0; i < 10; i++)
      u_sad_ctrl_model.issue(SAD_CMD_WRITE, 2'h0, 12'h1F0 + 12'(i), 16'hA000 + 16'(i));
    u_sad_ctrl_model.idle();
    check("acc_write", 16'(acc_write), 16'h0001);
    check("col_addr", 16'(col_addr), 16'h01F9);
    check("auto_precharge", 16'(auto_precharge), 16'h0000);
    check("bank_open", 16'(bank_open), 16'h0001);
    // far side stalls: output register plus eight-deep buffer hold nine, the tenth is refused
    repeat (4) @(posedge core_clk);
    #1;
    wr_ready = 1'b1;
    for (int t = 0; t < 20; t++)
    begin
      if (wr_valid === 1'b1)
      begin
        check("wr_data", wr_data, 16'hA000 + 16'(n));
        n++;
      end
      @(posedge core_clk);
      #1;
    end
    check("words_drained", 16'(n), 16'h0009);
    check("wr_valid", 16'(wr_valid), 16'h0000);
    $display("test_write_fifo done");
  endtask : test_write_fifo

  task automatic test_ignored();
    u_sad_ctrl_model.issue(SAD_CMD_ACTIVE, 2'h2, 12'h3C3, 16'h0000);
    u_sad_ctrl_model.issue(SAD_CMD_OTHER, 2'h2, 12'h400, 16'h0000);
    u_sad_ctrl_model.issue_masked(SAD_CMD_PRECHARGE, 2'h2, 12'h400);
    u_sad_ctrl_model.issue_masked(SAD_CMD_LOAD_MODE, 2'h2, 12'h0FF);
    u_sad_ctrl_model.issue_masked(SAD_CMD_READ, 2'h2, 12'h400);
    u_sad_ctrl_model.idle();
    check("acc_valid", 16'(acc_valid), 16'h0000);
    check("mode_opcode", 16'(mode_opcode), 16'h00A5);
    check("bank_open", 16'(bank_open), 16'h0005);
    $display("test_ignored done");
  endtask : test_ignored

  task automatic test_reset();
    @(posedge core_clk);
    #1;
    reset_n = 1'b0;
    @(posedge core_clk);
    #1;
    check("bank_open", 16'(bank_open), 16'h0000);
    check("rd_ready", 16'(rd_ready), 16'h0000);
    reset_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("rd_ready", 16'(rd_ready), 16'h0001);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_read_path();
    int t;
    @(posedge core_clk);
    #1;
    rd_valid = 1'b1;
    rd_data = 16'h5AC3;
    check("rd_ready", 16'(rd_ready), 16'h0001);
    @(posedge core_clk);
    #1;
    rd_valid = 1'b0;
    rd_data = 16'hA53C;
    for (t = 0; t < 4 && dq_oe !== 16'hFFFF; t++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (t == 4)
    begin
      errors++;
      results();
    end
    check("dq_out", dq_out, 16'h5AC3);
    check("dq_oe_x4", oe_x4, 16'h000F);
    check("dq_oe_x8", oe_x8, 16'h00FF);
    @(posedge core_clk);
    #1;
    check("dq_oe", dq_oe, 16'h0000);
    $display("test_read_path done");
  endtask : test_read_path

  initial
  begin
    errors = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    wr_ready = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    check("bank_open", 16'(bank_open), 16'h0000);
    test_open_read();
    test_precharge();
    test_mode();
    test_write_fifo();
    test_ignored();
    test_read_path();
    test_reset();
    results();
  end
endmodule : sad_decode_tb
